/* File: sim/dcs_host_model.sv */
// Host-side receiver model that takes debug acknowledge characters off the link.
module dcs_host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Character link
    input  wire logic       ack_valid,
    input  wire logic [7:0] ack_data,
    output logic            ack_ready,
    // Bench control
    input  wire logic       stall
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned rx_count;
    logic [7:0]  rx_last;

    // A slow host holds ready low, so the character must wait on the link.
    assign ack_ready = !stall;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_count <= 0;
            rx_last  <= 8'h00;
        end else if (ack_valid && ack_ready) begin
            rx_count <= rx_count + 1;
            rx_last  <= ack_data;
        end
    end
endmodule

/* File: sim/debugger_control_status_bench.sv */
// Self-checking bench for the debugger control and status block.
module debugger_control_status_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import dcs_pkg::*;
    localparam int RC = 4;
    logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, instr_decode = 0, halt_mode = 0;
    logic flash_read_protect = 1, read_protect_override = 0, stall = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, instr_opcode = 8'h00, reg_rdata, ack_data, d;
    logic fetch_stall, sys_reset_n, ack_valid, ack_ready, irq;
    int mismatches = 0, samples_checked = 0, cycles = 0, n;

    dcs_debug_ctrl #(.RESET_CYCLES(RC)) i_dcs_debug_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_decode(instr_decode),
        .instr_opcode(instr_opcode), .halt_mode(halt_mode), .flash_read_protect(flash_read_protect),
        .read_protect_override(read_protect_override), .fetch_stall(fetch_stall), .sys_reset_n(sys_reset_n),
        .ack_valid(ack_valid), .ack_data(ack_data), .ack_ready(ack_ready), .irq(irq));
    dcs_host_model i_dcs_host_model (.clk(clk), .reset_n(reset_n), .ack_valid(ack_valid), .ack_data(ack_data),
        .ack_ready(ack_ready), .stall(stall));

    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
    task automatic break_instruction(input logic [7:0] op);
        @(posedge clk);
        instr_decode <= 1;
        instr_opcode <= op;
        @(posedge clk);
        instr_decode <= 0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        rd(DCS_ADDR_CTRL, d);
        chk(d, DCS_CTRL_RESET);
        rd(DCS_ADDR_STAT, d);
        chk(d, DCS_STAT_RESET);
        chk({7'h0, irq}, 8'h00);
        $display("test reset values done");
    endtask
    task automatic t_status();
        halt_mode <= 1;
        rd(DCS_ADDR_STAT, d);
        chk(d, 8'h40);
        read_protect_override <= 1;
        rd(DCS_ADDR_STAT, d);
        chk(d, 8'h60);
        halt_mode <= 0;
        flash_read_protect <= 0;
        read_protect_override <= 0;
        wr(DCS_ADDR_STAT, 8'hFF);
        rd(DCS_ADDR_STAT, d);
        chk(d, 8'h20);
        rd(3'h7, d);
        chk(d, 8'h00);
        $display("test status done");
    endtask
    task automatic t_break();
        n = i_dcs_host_model.rx_count;
        stall <= 1;
        wr(DCS_ADDR_IRQ_MK, 8'h03);
        wr(DCS_ADDR_CTRL, 8'h40);
        break_instruction(8'h01);
        chk({7'h0, fetch_stall}, 8'h00);
        break_instruction(DCS_BRK_OPCODE);
        chk({7'h0, fetch_stall}, 8'h01);
        rd(DCS_ADDR_STAT, d);
        chk(d, 8'hA0);
        chk(i_dcs_host_model.rx_count - n, 8'h00);
        chk({7'h0, irq}, 8'h01);
        wr(DCS_ADDR_IRQ_ST, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(DCS_ADDR_CTRL, 8'h60);
        @(posedge clk);
        #1 chk({7'h0, fetch_stall}, 8'h00);
        break_instruction(DCS_BRK_OPCODE);
        repeat (3) @(posedge clk);
        #1 chk({ack_valid, 7'h0}, 8'h80);
        chk(ack_data, DCS_ACK_CHAR);
        stall <= 0;
        repeat (3) @(posedge clk);
        #1 chk(i_dcs_host_model.rx_count - n, 8'h01);
        chk(i_dcs_host_model.rx_last, DCS_ACK_CHAR);
        wr(DCS_ADDR_IRQ_ST, 8'h01);
        wr(DCS_ADDR_CTRL, 8'h00);
        break_instruction(DCS_BRK_OPCODE);
        chk({7'h0, fetch_stall}, 8'h00);
        flash_read_protect <= 1;
        wr(DCS_ADDR_CTRL, 8'h40);
        break_instruction(DCS_BRK_OPCODE);
        wr(DCS_ADDR_CTRL, 8'h40);
        chk({7'h0, fetch_stall}, 8'h01);
        read_protect_override <= 1;
        wr(DCS_ADDR_CTRL, 8'h00);
        chk({7'h0, fetch_stall}, 8'h00);
        wr(DCS_ADDR_IRQ_ST, 8'h01);
        $display("test break done");
    endtask
    task automatic t_sysreset();
        wr(DCS_ADDR_IRQ_MK, 8'h00);
        wr(DCS_ADDR_CTRL, 8'h41);
        n = 0;
        repeat (RC + 10) begin
            if (sys_reset_n === 1'b0) n++;
            @(posedge clk);
            #1;
        end
        chk(n, RC);
        rd(DCS_ADDR_CTRL, d);
        chk(d, 8'h40);
        rd(DCS_ADDR_IRQ_ST, d);
        chk(d, 8'h02);
        chk({7'h0, irq}, 8'h00);
        wr(DCS_ADDR_IRQ_MK, 8'h02);
        chk({7'h0, irq}, 8'h01);
        wr(DCS_ADDR_IRQ_ST, 8'h02);
        chk({7'h0, irq}, 8'h00);
        wr(DCS_ADDR_CTRL, 8'h40);
        n = 0;
        repeat (RC + 4) begin
            if (sys_reset_n !== 1'b1) n++;
            @(posedge clk);
            #1;
        end
        chk(n, 8'h00);
        $display("test system reset done");
    endtask

    task automatic conclude();
        $display("compared %0d, mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        t_reset();
        t_status();
        t_break();
        t_sysreset();
        conclude();
    end
endmodule

/* File: src/dcs_debug_ctrl.sv */
// Debugger control and status registers with breakpoint, acknowledge and reset request logic.
//
// Overview of operation
// R1: Breakpoint with ack enabled sends FFH.
// R2: Host writes zeros to reserved bits.
// R3: Writing one to bit 0 resets device.
// R4: Debugger-triggered reset spares the debugger itself.
// R5: Reset request bit clears after sequence.
// R6: Status bit 7 shows debug mode.
// R7: Status bit 6 shows halt mode.
// R8: Status bit 5 low when protect active.
// R9: Debug-mode bit stops instruction fetching.
// R10: Break instruction sets debug mode if enabled.
// R11: Status register writes are ignored.
module dcs_debug_ctrl
    import dcs_pkg::*;
#(
    parameter int RESET_CYCLES = DCS_RST_CYCLES
) (
    // Clock and power-on reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Processor side
    input  wire logic       instr_decode,
    input  wire logic [7:0] instr_opcode,
    input  wire logic       halt_mode,
    input  wire logic       flash_read_protect,
    input  wire logic       read_protect_override,
    output logic            fetch_stall,
    output logic            sys_reset_n,
    // Link to host transmitter
    output logic            ack_valid,
    output logic      [7:0] ack_data,
    input  wire logic       ack_ready,
    // Interrupt
    output logic            irq
);

    dcs_reg_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic               debug_mode_bit;
    logic               breakpoint_enable;
    logic               debug_ack_enable;
    logic               rst_req;
    logic [DCS_IRQ_W-1:0] irq_status;
    logic [DCS_IRQ_W-1:0] irq_mask;
    logic               seq_done;
    logic               prot_active;

    function automatic logic hit(input dcs_reg_req_t r, input logic [2:0] a);
        return r.wr && (r.addr == a);
    endfunction

    wire wr_ctrl  = hit(req, DCS_ADDR_CTRL);
    wire wr_irqst = hit(req, DCS_ADDR_IRQ_ST);
    wire wr_irqmk = hit(req, DCS_ADDR_IRQ_MK);

    // R10 break decode
    wire brk_hit = instr_decode && (instr_opcode == DCS_BRK_OPCODE) && breakpoint_enable && !debug_mode_bit;

    // R3 reset trigger
    wire rst_start = wr_ctrl && req.wdata[DCS_CTRL_RST_REQ] && !rst_req;

    // While protection is in force, software may not clear debug mode; only the power-on reset can.
    wire dbg_clear_ok = !prot_active;
    wire next_dbg = brk_hit ? 1'b1 :
                    wr_ctrl ? (req.wdata[DCS_CTRL_DEBUG_MODE] | (debug_mode_bit & !dbg_clear_ok)) :
                    debug_mode_bit;

    // R8 protect evaluation
    assign prot_active = flash_read_protect && !read_protect_override;

    // R4 debugger on power-on reset only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_mode_bit    <= DCS_CTRL_RESET[DCS_CTRL_DEBUG_MODE];
            breakpoint_enable <= DCS_CTRL_RESET[DCS_CTRL_BRK_EN];
            debug_ack_enable  <= DCS_CTRL_RESET[DCS_CTRL_ACK_EN];
        end else begin
            debug_mode_bit <= next_dbg;
            if (wr_ctrl) begin
                breakpoint_enable <= req.wdata[DCS_CTRL_BRK_EN];
                debug_ack_enable  <= req.wdata[DCS_CTRL_ACK_EN];
            end
        end
    end

    // R5 self clearing request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_req <= DCS_CTRL_RESET[DCS_CTRL_RST_REQ];
        end else if (rst_start) begin
            rst_req <= 1'b1;
        end else if (seq_done) begin
            rst_req <= 1'b0;
        end
    end

    dcs_reset_seq #(
        .CYCLES (RESET_CYCLES)
    ) u_seq (
        .clk         (clk),
        .reset_n     (reset_n),
        .start       (rst_start),
        .sys_reset_n (sys_reset_n),
        .done        (seq_done)
    );

    // R9 fetch stall
    assign fetch_stall = debug_mode_bit;

    // R1 acknowledge character; held until the host transmitter takes it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_valid <= 1'b0;
            ack_data  <= 8'h00;
        end else if (brk_hit && debug_ack_enable) begin
            ack_valid <= 1'b1;
            ack_data  <= DCS_ACK_CHAR;
        end else if (ack_ready) begin
            ack_valid <= 1'b0;
        end
    end

    // Interrupt events: set wins over write-one-to-clear.
    wire [DCS_IRQ_W-1:0] irq_event = {seq_done, brk_hit};
    wire [DCS_IRQ_W-1:0] irq_clr   = wr_irqst ? req.wdata[DCS_IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
            if (wr_irqmk) begin
                irq_mask <= req.wdata[DCS_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // R6 R7 R8 live status
    wire [7:0] stat_val = {debug_mode_bit, halt_mode, !prot_active, 5'h00};
    // R2 reserved control bits read zero
    wire [7:0] ctrl_val = {debug_mode_bit, breakpoint_enable, debug_ack_enable, 4'h0, rst_req};

    // R11 status is read only: no write decode exists for it.
    wire [7:0] rd_mux = (req.addr == DCS_ADDR_CTRL)   ? ctrl_val :
                        (req.addr == DCS_ADDR_STAT)   ? stat_val :
                        (req.addr == DCS_ADDR_IRQ_ST) ? {6'h00, irq_status} :
                        (req.addr == DCS_ADDR_IRQ_MK) ? {6'h00, irq_mask} : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= req.rd ? rd_mux : 8'h00;
        end
    end

    AST_ACK_SENT: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (brk_hit && debug_ack_enable) |=> (ack_valid && ack_data == 8'hFF))
        else $error("Acknowledge not sent.");
    AST_NO_ACK: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (!ack_valid && !(brk_hit && debug_ack_enable)) |=> !ack_valid)
        else $error("Acknowledge sent without cause.");
    AST_RST_START: assert property (@(posedge clk) disable iff (!reset_n) // R3
        rst_start |=> (rst_req && !sys_reset_n))
        else $error("Reset request not started.");
    AST_RST_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (wr_ctrl && !req.wdata[0] && !rst_req) |=> sys_reset_n)
        else $error("Writing zero caused reset.");
    AST_KEEP_STATE: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (!sys_reset_n && !wr_ctrl && !brk_hit) |=> $stable(breakpoint_enable) && $stable(debug_mode_bit))
        else $error("Debugger state lost during reset.");
    AST_RST_CLEAR: assert property (@(posedge clk) disable iff (!reset_n) // R5
        seq_done |=> !rst_req)
        else $error("Reset request not cleared.");
    AST_STAT_READ: assert property (@(posedge clk) disable iff (!reset_n) // R6
        (req.rd && req.addr == DCS_ADDR_STAT) |=>
        (reg_rdata[7] == $past(debug_mode_bit) && reg_rdata[6] == $past(halt_mode) && reg_rdata[4:0] == 5'h00))
        else $error("Status read wrong.");
    AST_PROT: assert property (@(posedge clk) disable iff (!reset_n) // R8
        (req.rd && req.addr == DCS_ADDR_STAT) |=> reg_rdata[5] == !$past(prot_active))
        else $error("Protect status wrong.");
    AST_BRK: assert property (@(posedge clk) disable iff (!reset_n) // R10
        brk_hit |=> (debug_mode_bit && fetch_stall))
        else $error("Break did not enter debug mode.");
    AST_STAT_WR: assert property (@(posedge clk) disable iff (!reset_n) // R11
        hit(req, DCS_ADDR_STAT) |=> $stable(irq_mask) && $stable(breakpoint_enable))
        else $error("Status write had effect.");

    COV_BREAK: cover property (@(posedge clk) disable iff (!reset_n) brk_hit && debug_ack_enable);
    COV_RESET: cover property (@(posedge clk) disable iff (!reset_n) seq_done);
    COV_IRQ:   cover property (@(posedge clk) disable iff (!reset_n) irq);

endmodule

/* File: src/dcs_pkg.sv */
// Package holding register map, field layout and timing constants of the debugger control and status block.
package dcs_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] DCS_ADDR_CTRL   = 3'h0;
    localparam logic [2:0] DCS_ADDR_STAT   = 3'h1;
    localparam logic [2:0] DCS_ADDR_IRQ_ST = 3'h2;
    localparam logic [2:0] DCS_ADDR_IRQ_MK = 3'h3;

    // Control register fields.
    localparam int DCS_CTRL_DEBUG_MODE = 7;
    localparam int DCS_CTRL_BRK_EN     = 6;
    localparam int DCS_CTRL_ACK_EN     = 5;
    localparam int DCS_CTRL_RST_REQ    = 0;

    // Status register fields.
    localparam int DCS_STAT_DEBUG  = 7;
    localparam int DCS_STAT_HALT   = 6;
    localparam int DCS_STAT_READ_PROTECT_OVERRIDE = 5;

    // Interrupt status fields.
    localparam int DCS_IRQ_BREAK     = 0;
    localparam int DCS_IRQ_RESET_END = 1;
    localparam int DCS_IRQ_W         = 2;

    localparam logic [7:0] DCS_CTRL_RESET = 8'h00;
    localparam logic [7:0] DCS_STAT_RESET = 8'h00;
    localparam logic [7:0] DCS_ACK_CHAR   = 8'hFF;
    localparam logic [7:0] DCS_BRK_OPCODE = 8'h00;

    // Length of the device reset pulse requested from the debugger.
    localparam int DCS_RST_TIME_NS = 100;
    localparam int DCS_CLK_NS      = 5;
    localparam int DCS_RST_CYCLES  = (DCS_RST_TIME_NS + DCS_CLK_NS - 1) / DCS_CLK_NS;

    // Register access group.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dcs_reg_req_t;

endpackage

/* File: src/dcs_reset_seq.sv */
// Counter that stretches a reset request into a system reset pulse and signals its end.
module dcs_reset_seq
    import dcs_pkg::*;
#(
    parameter int CYCLES = DCS_RST_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Request and sequence
    input  wire logic start,
    output logic      sys_reset_n,
    output logic      done
);

    initial begin
        if (CYCLES < 1 || CYCLES > 65535) begin
            $error("dcs_reset_seq: CYCLES out of range");
        end
    end

    // Delay from the first low cycle of the pulse to the cycle in which it has ended.
    localparam int SEQ_D = CYCLES;

    logic [15:0] count;
    logic        busy;

    wire last = busy && (count == 16'h0001);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 16'h0000;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= last;
            if (start && !busy) begin
                busy  <= 1'b1;
                count <= 16'(CYCLES);
            end else if (busy) begin
                count <= count - 16'h0001;
                if (last) begin
                    busy <= 1'b0;
                end
            end
        end
    end

    assign sys_reset_n = !busy;

    AST_SEQ_LEN: assert property (@(posedge clk) disable iff (!reset_n)
        (start && !busy) |=> !sys_reset_n ##SEQ_D (sys_reset_n && done))
        else $error("Reset pulse length wrong.");

endmodule
